// *** sim/dual_uart_host_bus_config_test.sv ***
module dual_uart_host_bus_config_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic       clk;
  logic       rst_n;
  logic       bus_style_pin;
  logic       prescaler_select_pin;
  logic       reset_pin;
  logic       rx_a;
  logic       rx_b;
  logic       read_strobe_n;
  logic       write_strobe_n;
  logic       chan_a_select_n;
  logic       chan_b_select_n;
  logic       channel_address_bit;
  logic       rd_wr_n;
  logic [2:0] reg_addr;
  logic [7:0] data_in;
  logic [7:0] data_out;
  logic       data_oe;
  logic       tx_a;
  logic       tx_b;
  logic       div4_a;
  logic       div4_b;
  int         err_count;
  int         comparisons;
  int         cycles;

  duart_host_port #(.FIFO_DEPTH(duart_host_pkg::FIFO_DEPTH)) i_dut (
    .clk(clk), .rst_n(rst_n), .bus_style_pin(bus_style_pin),
    .prescaler_select_pin(prescaler_select_pin), .reset_pin(reset_pin),
    .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
    .chan_a_select_n(chan_a_select_n), .chan_b_select_n(chan_b_select_n),
    .channel_address_bit(channel_address_bit), .rd_wr_n(rd_wr_n), .reg_addr(reg_addr),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .rx_a(rx_a), .rx_b(rx_b),
    .tx_a(tx_a), .tx_b(tx_b), .div4_a(div4_a), .div4_b(div4_b));

  host_cpu_model host (
    .clk(clk), .bus_style(bus_style_pin), .data_out(data_out), .data_oe(data_oe),
    .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
    .chan_a_select_n(chan_a_select_n), .chan_b_select_n(chan_b_select_n),
    .channel_address_bit(channel_address_bit), .rd_wr_n(rd_wr_n), .reg_addr(reg_addr),
    .data_in(data_in));

  always #4 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    if (err_count == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error at %0t: byte %h, expected %h", $time, got, exp);
    end
  endtask : check8

  task automatic check1(input logic got, input logic exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask : check1

  task automatic rd_chk(input logic [1:0] sel, input logic [2:0] addr, input logic [7:0] exp);
    logic [7:0] rdata;
    logic       oe;
    host.read_reg(sel, addr, rdata, oe);
    check8(rdata, exp);
    check1(oe, 1'b1);
  endtask : rd_chk

  // pin is driven to the active level for len+1 cycles, rx_a pulled low meanwhile
  task automatic dev_reset(input logic active, input int len);
    @(posedge clk);
    reset_pin <= active;
    rx_a <= 1'b0;
    repeat (len) @(posedge clk);
    #1;
    check1(tx_a, 1'b1);
    check1(tx_b, 1'b1);
    @(posedge clk);
    reset_pin <= !active;
    rx_a <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : dev_reset

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      err_count++;
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    bus_style_pin = 1'b1;
    prescaler_select_pin = 1'b1;
    reset_pin = 1'b0;
    rx_a = 1'b1;
    rx_b = 1'b1;
    err_count = 0;
    comparisons = 0;
    cycles = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    for (int c = 1; c <= 2; c++)
    begin
      rd_chk(c[1:0], 3'h1, 8'h00);
      rd_chk(c[1:0], 3'h2, 8'h01);
      rd_chk(c[1:0], 3'h3, 8'h00);
      rd_chk(c[1:0], 3'h4, 8'h00);
      rd_chk(c[1:0], 3'h5, 8'h60);
      rd_chk(c[1:0], 3'h6, 8'h00);
      rd_chk(c[1:0], 3'h7, 8'hff);
    end
    check1(div4_a, 1'b0);
    host.write_reg(2'b01, 3'h7, 8'h5a);
    rd_chk(2'b01, 3'h7, 8'h5a);
    rd_chk(2'b10, 3'h7, 8'hff);
    host.write_reg(2'b11, 3'h3, 8'h03);
    rd_chk(2'b01, 3'h3, 8'h03);
    rd_chk(2'b10, 3'h3, 8'h03);
    host.write_reg(2'b00, 3'h7, 8'h11);
    rd_chk(2'b01, 3'h7, 8'h5a);
    // strap moved after reset must not reach the divider
    prescaler_select_pin <= 1'b0;
    repeat (4) @(posedge clk);
    check1(div4_a, 1'b0);
    rd_chk(2'b01, 3'h4, 8'h00);
    host.write_reg(2'b01, 3'h4, 8'h80);
    rd_chk(2'b01, 3'h4, 8'h80);
    check1(div4_a, 1'b1);
    check1(div4_b, 1'b0);
    // a pulse shorter than the minimum is filtered
    dev_reset(1'b1, 3);
    rd_chk(2'b01, 3'h7, 8'h5a);
    dev_reset(1'b1, 6);
    rd_chk(2'b01, 3'h7, 8'hff);
    rd_chk(2'b10, 3'h3, 8'h00);
    rd_chk(2'b01, 3'h4, 8'h80);
    rd_chk(2'b10, 3'h4, 8'h80);
    check1(div4_b, 1'b1);
    rd_chk(2'b01, 3'h5, 8'h60);
    // fill the transmit buffer of channel a; nothing drains it
    host.write_reg(2'b01, 3'h2, 8'h01);
    for (int i = 0; i < duart_host_pkg::FIFO_DEPTH - 1; i++)
      host.write_reg(2'b01, 3'h0, i[7:0]);
    rd_chk(2'b01, 3'h5, 8'h20);
    host.write_reg(2'b01, 3'h0, 8'hee);
    rd_chk(2'b01, 3'h5, 8'h00);
    rd_chk(2'b10, 3'h5, 8'h60);
    // direction-line style; reset pin idles high here
    @(posedge clk);
    rst_n <= 1'b0;
    bus_style_pin <= 1'b0;
    reset_pin <= 1'b1;
    prescaler_select_pin <= 1'b1;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rd_chk(2'b01, 3'h7, 8'hff);
    host.write_reg(2'b10, 3'h7, 8'h33);
    rd_chk(2'b10, 3'h7, 8'h33);
    rd_chk(2'b01, 3'h7, 8'hff);
    host.write_reg(2'b00, 3'h7, 8'h44);
    rd_chk(2'b10, 3'h7, 8'h33);
    dev_reset(1'b0, 6);
    rd_chk(2'b10, 3'h7, 8'hff);
    rd_chk(2'b10, 3'h4, 8'h00);
    stop_test();
  end
endmodule : dual_uart_host_bus_config_test

// *** sim/host_cpu_model.sv ***
module host_cpu_model (
  input  wire logic       clk,
  input  wire logic       bus_style,
  input  wire logic [7:0] data_out,
  input  wire logic       data_oe,
  output logic            read_strobe_n,
  output logic            write_strobe_n,
  output logic            chan_a_select_n,
  output logic            chan_b_select_n,
  output logic            channel_address_bit,
  output logic            rd_wr_n,
  output logic      [2:0] reg_addr,
  output logic      [7:0] data_in
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    chan_a_select_n = 1'b1;
    chan_b_select_n = 1'b1;
    channel_address_bit = 1'b0;
    rd_wr_n = 1'b1;
    reg_addr = 3'h0;
    data_in = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // a released bus shows the inverse, so stale values never look valid
  task automatic release_bus();
    read_strobe_n <= 1'b1;
    write_strobe_n <= 1'b1;
    chan_a_select_n <= 1'b1;
    chan_b_select_n <= 1'b1;
    rd_wr_n <= 1'b1;
    reg_addr <= ~reg_addr;
    data_in <= ~data_in;
  endtask : release_bus

  // sel bit0 = channel a, bit1 = channel b; never both on a read
  task automatic drive(input logic [1:0] sel, input logic rd, input logic [2:0] addr,
                       input logic [7:0] wdata);
    if (bus_style)
    begin
      read_strobe_n <= !rd;
      write_strobe_n <= rd;
      chan_a_select_n <= !sel[0];
      chan_b_select_n <= !sel[1];
    end
    else
    begin
      chan_a_select_n <= (sel == 2'b00);
      channel_address_bit <= sel[1];
      rd_wr_n <= rd;
    end
    reg_addr <= addr;
    data_in <= wdata;
  endtask : drive

  task automatic write_reg(input logic [1:0] sel, input logic [2:0] addr,
                           input logic [7:0] wdata);
    @(posedge clk);
    drive(sel, 1'b0, addr, wdata);
    @(posedge clk);
    release_bus();
    @(posedge clk);
  endtask : write_reg

  task automatic read_reg(input logic [1:0] sel, input logic [2:0] addr,
                          output logic [7:0] rdata, output logic oe);
    @(posedge clk);
    drive(sel, 1'b1, addr, ~data_in);
    @(posedge clk);
    release_bus();
    #1;
    rdata = data_out;
    oe = data_oe;
    @(posedge clk);
  endtask : read_reg
endmodule : host_cpu_model

// *** src/byte_fifo_if.sv ***
interface byte_fifo_if #(
  parameter int unsigned WIDTH = 8
);
  logic             flush;
  logic             push;
  logic [WIDTH-1:0] wdata;
  logic             pop;
  logic [WIDTH-1:0] rdata;
  logic             full;
  logic             empty;

  modport user (output flush, output push, output wdata, output pop,
                input rdata, input full, input empty);
  modport store (input flush, input push, input wdata, input pop,
                 output rdata, output full, output empty);
endinterface : byte_fifo_if

// *** src/byte_fifo_mem.sv ***
module byte_fifo_mem #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 32
) (
  input wire logic    clk,
  input wire logic    rst_n,
  byte_fifo_if.store  port
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wptr_reg;
  logic [AW-1:0]    rptr_reg;
  logic [AW:0]      count_reg;
  logic [WIDTH-1:0] rdata_reg;

  wire do_push = port.push && !port.full;
  wire do_pop  = port.pop && !port.empty;

  assign port.full  = (count_reg == (AW+1)'(DEPTH));
  assign port.empty = (count_reg == '0);
  assign port.rdata = rdata_reg;

  always_ff @(posedge clk)
  begin
    if (do_push)
    begin
      mem[wptr_reg] <= port.wdata;
    end
  end

  // head word is registered; it lags a pop by one cycle
  always_ff @(posedge clk)
  begin
    rdata_reg <= mem[rptr_reg];
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n || port.flush)
    begin
      wptr_reg  <= '0;
      rptr_reg  <= '0;
      count_reg <= '0;
    end
    else
    begin
      if (do_push)
      begin
        wptr_reg <= AW'(wptr_reg + 1'b1);
      end
      if (do_pop)
      begin
        rptr_reg <= AW'(rptr_reg + 1'b1);
      end
      if (do_push && !do_pop)
      begin
        count_reg <= (AW+1)'(count_reg + 1'b1);
      end
      else if (do_pop && !do_push)
      begin
        count_reg <= (AW+1)'(count_reg - 1'b1);
      end
    end
  end

endmodule : byte_fifo_mem

// *** src/duart_host_pkg.sv ***
// Operation
// RL1: bus style pin high selects the strobe host port style.
// RL2: bus style pin low selects the select plus direction line style.
// RL3: strobe style transfers use read or write strobe with a channel select.
// RL4: direction style transfers use single select, direction line and channel bit.
// RL5: two channels share one host port, each with its own registers.
// RL6: writing one channel never changes the other channel's configuration.
// RL7: each channel has 32 byte transmit and receive buffers.
// RL8: prescaler pin is sampled only during reset, ignored otherwise.
// RL9: prescaler pin high divides by 1, low divides by 4, both channels.
// RL10: software overrides the prescaler choice via modem control bit 7.
// RL11: in strobe style the reset pin is active high.
// RL12: in direction style the reset pin is active low.
// RL13: reset held at least 40 ns returns both channels to defaults.
// RL14: serial transmit outputs stay high while reset is active.
// RL15: serial receive inputs are ignored while reset is active.
// RL16: register defaults after reset match the classic single uart set.
// RL17: both strobe selects low write both channels; never read so.
// RL18: direction style: channel bit 0 picks a, 1 picks b, select high none.
// RL19: host transfers need only strobes and selects, no uart clock; the code samples strobes and selects on clk and writes registers on it.
// RL20: bus style pin is fixed from power up on.
package duart_host_pkg;

  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned RST_MIN_NS    = 40;
  localparam int unsigned RST_MIN_CYC   = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int unsigned FIFO_DEPTH = 32;
  localparam int unsigned DATA_W     = 8;

  // register offsets
  localparam logic [2:0] OFS_DATA  = 3'h0;
  localparam logic [2:0] OFS_IER   = 3'h1;
  localparam logic [2:0] OFS_FCR   = 3'h2;
  localparam logic [2:0] OFS_LCR   = 3'h3;
  localparam logic [2:0] OFS_MODEM_CTL = 3'h4;
  localparam logic [2:0] OFS_LSR   = 3'h5;
  localparam logic [2:0] OFS_MSR   = 3'h6;
  localparam logic [2:0] OFS_SPR   = 3'h7;

  // field positions
  localparam int unsigned LCR_DLAB_BIT   = 7;
  localparam int unsigned MODEM_CTL_DIV4_BIT = 7;
  localparam int unsigned MODEM_CTL_LOOP_BIT = 4;
  localparam int unsigned FCR_EN_BIT     = 0;
  localparam int unsigned FCR_RXCLR_BIT  = 1;
  localparam int unsigned FCR_TXCLR_BIT  = 2;
  localparam int unsigned IER_RX_BIT     = 0;
  localparam int unsigned IER_TX_BIT     = 1;

  // reset values
  localparam logic [7:0] IER_RST = 8'h00;
  localparam logic [7:0] LCR_RST = 8'h00;
  localparam logic [6:0] MODEM_CTL_RST = 7'h00;
  localparam logic [7:0] SPR_RST = 8'hff;
  localparam logic [7:0] DLL_RST = 8'h00;
  localparam logic [7:0] DLM_RST = 8'h00;

  // status codes
  localparam logic [3:0] ISR_NONE = 4'h1;
  localparam logic [3:0] ISR_TX   = 4'h2;
  localparam logic [3:0] ISR_RX   = 4'h4;
  localparam logic [1:0] ISR_FIFO = 2'h3;

endpackage : duart_host_pkg

// *** src/duart_host_port.sv ***
module duart_host_port #(
  parameter int unsigned FIFO_DEPTH = duart_host_pkg::FIFO_DEPTH
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       bus_style_pin,
  input  wire logic       prescaler_select_pin,
  input  wire logic       reset_pin,
  input  wire logic       read_strobe_n,
  input  wire logic       write_strobe_n,
  input  wire logic       chan_a_select_n,
  input  wire logic       chan_b_select_n,
  input  wire logic       channel_address_bit,
  input  wire logic       rd_wr_n,
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] data_in,
  output logic      [7:0] data_out,
  output logic            data_oe,
  input  wire logic       rx_a,
  input  wire logic       rx_b,
  output logic            tx_a,
  output logic            tx_b,
  output logic            div4_a,
  output logic            div4_b
);

  //////////////////////////////////////////////////////////////////////////////
  // bus style and reset pin qualification

  logic       pin_act;
  logic [2:0] rst_cnt_reg;
  logic       dev_rst_reg;
  logic       clr;

  // reset pin polarity follows the bus style
  assign pin_act = bus_style_pin ? reset_pin : !reset_pin; // RL11 RL12

  always_ff @(posedge clk)
  begin
    if (!rst_n || !pin_act)
    begin
      rst_cnt_reg <= 3'h0;
    end
    else if (rst_cnt_reg != 3'(duart_host_pkg::RST_MIN_CYC - 1))
    begin
      rst_cnt_reg <= 3'(rst_cnt_reg + 3'h1);
    end
  end

  // short glitches on the reset pin do not wipe the channels
  always_ff @(posedge clk)
  begin
    dev_rst_reg <= !rst_n ||
      (pin_act && rst_cnt_reg == 3'(duart_host_pkg::RST_MIN_CYC - 1)); // RL13
  end

  assign clr = !rst_n || dev_rst_reg;

  //////////////////////////////////////////////////////////////////////////////
  // host transfer decode

  function automatic logic [1:0] chan_mask(input logic style, input logic sa_n,
                                           input logic sb_n, input logic abit);
    if (style)
    begin
      chan_mask = {!sb_n, !sa_n}; // RL17
    end
    else
    begin
      chan_mask = sa_n ? 2'b00 : (abit ? 2'b10 : 2'b01); // RL18
    end
  endfunction : chan_mask

  logic [1:0] sel;
  logic       rd_act;
  logic       wr_act;
  logic       rd_prev_reg;
  logic       wr_prev_reg;
  logic       rd_go;
  logic       wr_go;
  logic [1:0] wr_mask;
  logic       rd_ch;

  assign sel = chan_mask(bus_style_pin, chan_a_select_n, chan_b_select_n,
                         channel_address_bit); // RL5

  always_comb
  begin
    if (bus_style_pin)
    begin
      rd_act = !read_strobe_n && (sel != 2'b00); // RL1 RL3
      wr_act = !write_strobe_n && (sel != 2'b00); // RL3
    end
    else
    begin
      rd_act = (sel != 2'b00) && rd_wr_n; // RL2 RL4
      wr_act = (sel != 2'b00) && !rd_wr_n; // RL4
    end
  end

  always_ff @(posedge clk)
  begin
    if (clr)
    begin
      rd_prev_reg <= 1'b0;
      wr_prev_reg <= 1'b0;
    end
    else
    begin
      rd_prev_reg <= rd_act;
      wr_prev_reg <= wr_act;
    end
  end

  // one action per strobe; the register bus is sampled and written on clk
  assign rd_go   = rd_act && !rd_prev_reg; // RL19
  assign wr_go   = wr_act && !wr_prev_reg;
  assign wr_mask = wr_go ? sel : 2'b00;
  // a read with both selects low is host misuse; channel a answers
  assign rd_ch   = !sel[0];

  //////////////////////////////////////////////////////////////////////////////
  // per channel register sets

  logic [1:0][7:0] ier_reg;
  logic [1:0][7:0] lcr_reg;
  logic [1:0][7:0] modem_control_reg;
  logic [1:0][7:0] spr_reg;
  logic [1:0][7:0] dll_reg;
  logic [1:0][7:0] dlm_reg;
  logic [1:0]      fifo_en_reg;
  logic [1:0]      rx_line_reg;
  logic [1:0]      loop_wait_reg;

  always_ff @(posedge clk)
  begin
    for (int c = 0; c < 2; c++)
    begin
      if (clr)
      begin
        ier_reg[c]     <= duart_host_pkg::IER_RST; // RL16
        lcr_reg[c]     <= duart_host_pkg::LCR_RST;
        spr_reg[c]     <= duart_host_pkg::SPR_RST;
        dll_reg[c]     <= duart_host_pkg::DLL_RST;
        dlm_reg[c]     <= duart_host_pkg::DLM_RST;
        fifo_en_reg[c] <= 1'b0;
        // strap caught while reset is active
        modem_control_reg[c] <= {!prescaler_select_pin, duart_host_pkg::MODEM_CTL_RST}; // RL8 RL9
      end
      else if (wr_mask[c]) // RL6
      begin
        unique case (reg_addr)
          duart_host_pkg::OFS_DATA:
          begin
            if (lcr_reg[c][duart_host_pkg::LCR_DLAB_BIT])
            begin
              dll_reg[c] <= data_in;
            end
          end
          duart_host_pkg::OFS_IER:
          begin
            if (lcr_reg[c][duart_host_pkg::LCR_DLAB_BIT])
            begin
              dlm_reg[c] <= data_in;
            end
            else
            begin
              ier_reg[c] <= data_in;
            end
          end
          duart_host_pkg::OFS_FCR: fifo_en_reg[c] <= data_in[duart_host_pkg::FCR_EN_BIT];
          duart_host_pkg::OFS_LCR: lcr_reg[c] <= data_in;
          duart_host_pkg::OFS_MODEM_CTL: modem_control_reg[c] <= data_in; // RL10
          duart_host_pkg::OFS_SPR: spr_reg[c] <= data_in;
          duart_host_pkg::OFS_LSR,
          duart_host_pkg::OFS_MSR: ;
        endcase
      end
    end
  end

  // receive line only observed out of reset
  always_ff @(posedge clk)
  begin
    if (clr)
    begin
      rx_line_reg <= 2'b11; // RL15
    end
    else
    begin
      rx_line_reg <= {rx_b, rx_a};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // buffers and internal loopback

  byte_fifo_if #(.WIDTH(duart_host_pkg::DATA_W)) tx_if [2] ();
  byte_fifo_if #(.WIDTH(duart_host_pkg::DATA_W)) rx_if [2] ();

  logic [1:0] tx_full;
  logic [1:0] tx_empty;
  logic [1:0] rx_empty;
  logic [1:0] rx_full;
  logic [1:0] loop_move;
  logic [1:0][7:0] rx_head;
  logic [1:0] rx_pop;

  for (genvar c = 0; c < 2; c++)
  begin : g_chan
    logic dlab;
    assign dlab = lcr_reg[c][duart_host_pkg::LCR_DLAB_BIT];

    byte_fifo_mem #(
      .WIDTH (duart_host_pkg::DATA_W),
      .DEPTH (FIFO_DEPTH)
    ) u_tx (
      .clk   (clk),
      .rst_n (rst_n),
      .port  (tx_if[c])
    ); // RL7

    byte_fifo_mem #(
      .WIDTH (duart_host_pkg::DATA_W),
      .DEPTH (FIFO_DEPTH)
    ) u_rx (
      .clk   (clk),
      .rst_n (rst_n),
      .port  (rx_if[c])
    ); // RL7

    assign tx_if[c].flush = dev_rst_reg || (wr_mask[c] && reg_addr == duart_host_pkg::OFS_FCR
                            && data_in[duart_host_pkg::FCR_TXCLR_BIT]);
    assign rx_if[c].flush = dev_rst_reg || (wr_mask[c] && reg_addr == duart_host_pkg::OFS_FCR
                            && data_in[duart_host_pkg::FCR_RXCLR_BIT]);
    assign tx_if[c].push  = wr_mask[c] && reg_addr == duart_host_pkg::OFS_DATA && !dlab;
    assign tx_if[c].wdata = data_in;
    assign tx_if[c].pop   = loop_move[c];
    assign rx_if[c].push  = loop_move[c];
    assign rx_if[c].wdata = tx_if[c].rdata;
    assign rx_if[c].pop   = rx_pop[c];
    assign rx_pop[c]      = rd_go && rd_ch == 1'(c) && reg_addr == duart_host_pkg::OFS_DATA
                            && !dlab;
    assign tx_full[c]     = tx_if[c].full;
    assign tx_empty[c]    = tx_if[c].empty;
    assign rx_full[c]     = rx_if[c].full;
    assign rx_empty[c]    = rx_if[c].empty;
    assign rx_head[c]     = rx_if[c].rdata;
    // every other cycle so the registered head word has caught up
    assign loop_move[c]   = modem_control_reg[c][duart_host_pkg::MODEM_CTL_LOOP_BIT]
                            && !loop_wait_reg[c]
                            && !tx_empty[c] && !rx_full[c];
  end

  always_ff @(posedge clk)
  begin
    if (clr)
    begin
      loop_wait_reg <= 2'b00;
    end
    else
    begin
      loop_wait_reg <= loop_move;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read data and outputs

  logic [7:0] rd_val;
  logic [7:0] ch_lcr;
  logic [7:0] ch_ier;

  always_comb
  begin
    ch_lcr = lcr_reg[rd_ch];
    ch_ier = ier_reg[rd_ch];
    rd_val = 8'h00;
    unique case (reg_addr)
      duart_host_pkg::OFS_DATA: rd_val = ch_lcr[duart_host_pkg::LCR_DLAB_BIT] ?
                                         dll_reg[rd_ch] : rx_head[rd_ch];
      duart_host_pkg::OFS_IER:  rd_val = ch_lcr[duart_host_pkg::LCR_DLAB_BIT] ?
                                         dlm_reg[rd_ch] : ch_ier;
      duart_host_pkg::OFS_FCR:
      begin
        rd_val[7:6] = fifo_en_reg[rd_ch] ? duart_host_pkg::ISR_FIFO : 2'h0;
        if (ch_ier[duart_host_pkg::IER_RX_BIT] && !rx_empty[rd_ch])
        begin
          rd_val[3:0] = duart_host_pkg::ISR_RX;
        end
        else if (ch_ier[duart_host_pkg::IER_TX_BIT] && tx_empty[rd_ch])
        begin
          rd_val[3:0] = duart_host_pkg::ISR_TX;
        end
        else
        begin
          rd_val[3:0] = duart_host_pkg::ISR_NONE;
        end
      end
      duart_host_pkg::OFS_LCR:  rd_val = ch_lcr;
      duart_host_pkg::OFS_MODEM_CTL: rd_val = modem_control_reg[rd_ch];
      duart_host_pkg::OFS_LSR:  rd_val = {1'b0, tx_empty[rd_ch], !tx_full[rd_ch],
                                          !rx_line_reg[rd_ch], 3'h0, !rx_empty[rd_ch]};
      duart_host_pkg::OFS_MSR:  rd_val = 8'h00;
      duart_host_pkg::OFS_SPR:  rd_val = spr_reg[rd_ch];
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (clr)
    begin
      data_out <= 8'h00;
      data_oe  <= 1'b0;
    end
    else
    begin
      if (rd_go)
      begin
        data_out <= rd_val;
      end
      data_oe <= rd_act; // RL3 RL4
    end
  end

  // serial engines live elsewhere; the line idles high here
  always_ff @(posedge clk)
  begin
    tx_a   <= 1'b1; // RL14
    tx_b   <= 1'b1; // RL14
    div4_a <= clr ? 1'b0 : modem_control_reg[0][duart_host_pkg::MODEM_CTL_DIV4_BIT]; // RL9
    div4_b <= clr ? 1'b0 : modem_control_reg[1][duart_host_pkg::MODEM_CTL_DIV4_BIT]; // RL9
  end

  //////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_reset_filter_high: assert property ((bus_style_pin && reset_pin) [*5] |=> dev_rst_reg) // RL11
    else $error("active high reset not taken");
  a_reset_filter_low: assert property ((!bus_style_pin && !reset_pin) [*5] |=> dev_rst_reg) // RL12
    else $error("active low reset not taken");
  a_short_glitch: assert property ($rose(pin_act) ##1 !pin_act |=> !dev_rst_reg) // RL13
    else $error("reset glitch acted");
  a_defaults_restored: assert property (dev_rst_reg |=> lcr_reg == '0 && ier_reg == '0
                                        && spr_reg[1] == 8'hff) // RL16
    else $error("defaults not restored");
  a_strap_sampled: assert property (dev_rst_reg |=>
                                    modem_control_reg[0][7] == !$past(prescaler_select_pin)
                                    && modem_control_reg[1][7] == modem_control_reg[0][7]) // RL9
    else $error("prescaler strap wrong");
  a_strap_ignored: assert property (!dev_rst_reg && !wr_go ##1 !dev_rst_reg
                                    |-> $stable(modem_control_reg)) // RL8
    else $error("strap changed modem control");
  a_tx_idle: assert property (tx_a && tx_b) // RL14
    else $error("tx left idle");
  a_rx_ignored: assert property (dev_rst_reg |=> rx_line_reg == 2'b11) // RL15
    else $error("rx seen in reset");
  a_chan_isolate: assert property (!dev_rst_reg && wr_mask == 2'b01 |=> $stable(lcr_reg[1])
                                   && $stable(spr_reg[1])) // RL6
    else $error("channel b disturbed");
  a_dual_write: assert property (!dev_rst_reg && bus_style_pin && wr_go && sel == 2'b11
                                 && reg_addr == 3'h7 |=> spr_reg[0] == spr_reg[1]) // RL17
    else $error("dual write missed");
  a_dir_decode: assert property (!bus_style_pin && !chan_a_select_n |->
                                 sel == (channel_address_bit ? 2'b10 : 2'b01)) // RL18
    else $error("channel bit decode wrong");
  a_read_drive: assert property (!dev_rst_reg && rd_go ##1 !dev_rst_reg |->
                                 data_oe && data_out == $past(rd_val)) // RL19
    else $error("read data missing");

  c_dual_write: cover property (bus_style_pin && wr_go && sel == 2'b11);
  c_dir_read: cover property (!bus_style_pin && rd_go && sel == 2'b10);
  c_loop_move: cover property (loop_move[0] ##2 rx_pop[0]);
  c_div1_strap: cover property (dev_rst_reg ##1 !dev_rst_reg && !div4_a);

endmodule : duart_host_port
